//--- shared/omc_defines.vh
// Constants for the operating mode controller: register offsets, field
// positions, reset values, mode and command codes and timing counts.
// Assumes it is included once by bare name from each design file.
`ifndef OMC_DEFINES_VH
`define OMC_DEFINES_VH

`define OMC_ADDR_W 4
`define OMC_DATA_W 8

`define OMC_OFS_SYSTEM_OPTIONS_1 4'h0
`define OMC_OFS_DEBUG_CONTROL 4'h1
`define OMC_OFS_POWER_CONTROL 4'h2
`define OMC_OFS_CLOCK_SOURCE_CONTROL_1 4'h3
`define OMC_OFS_MODE_STATUS 4'h4
`define OMC_OFS_DEBUG_FORCE_RESET_REG 4'h5

`define OMC_BIT_DEBUG_PIN_ENABLE 0
`define OMC_BIT_STOP_INSTRUCTION_ENABLE 1
`define OMC_BIT_DEBUG_MODE_ENABLE 0
`define OMC_BIT_PPD_SELECT 0
`define OMC_BIT_LOWVOLT_DETECT_ENABLE 1
`define OMC_BIT_LOWVOLT_STOP_ENABLE 2
`define OMC_BIT_PPD_FLAG 3
`define OMC_BIT_PPD_ACK 4
`define OMC_BIT_INTERNAL_REF_CLOCK_ENABLE 0
`define OMC_BIT_INTERNAL_REF_STOP_ENABLE 1
`define OMC_BIT_ADC_ASYNC_CLOCK_ENABLE 2
`define OMC_BIT_FORCE_RESET 0

`define OMC_RST_DEBUG_PIN_ENABLE 1'h1
`define OMC_RST_STOP_INSTRUCTION_ENABLE 1'h0
`define OMC_RST_DEBUG_MODE_ENABLE 1'h0

`define OMC_MODE_SAMPLE 3'h0
`define OMC_MODE_RUN 3'h1
`define OMC_MODE_BACKGROUND 3'h2
`define OMC_MODE_WAIT 3'h3
`define OMC_MODE_STANDBY_STOP 3'h4
`define OMC_MODE_PPD_STOP 3'h5

`define OMC_CMD_MEM 3'h0
`define OMC_CMD_MEM_STATUS 3'h1
`define OMC_CMD_DEBUG_REG 3'h2
`define OMC_CMD_HALT 3'h3
`define OMC_CMD_CPU_REG 3'h4
`define OMC_CMD_TRACE 3'h5
`define OMC_CMD_GO 3'h6

`define OMC_BIT_CYCLES 16
`define OMC_ZERO_LOW_CYCLES 5'h0d
`define OMC_ONE_LOW_CYCLES 5'h04
`define OMC_SPEEDUP_CYCLES 5'h01
`define OMC_SAMPLE_CYCLES 4

`endif

//--- hw/omc_operating_mode_controller.v
// Operating mode controller: reset mode sampling, debug command gating,
// wait and stop mode sequencing, and the debug pin bit timer.
// Assumes one bus clock, rst covering power-on and debug-forced reset,
// and a debug controller that decodes serial commands into cmd_code.
//
// Summary of operation
// [RQ1] During reset the shared debug pin is a mode select input only.
// [RQ2] Once reset ends the pin works as the debug communication pin.
// [RQ3] Pull-up on the debug pin is on whenever the pin enable is 1.
// [RQ4] Every reset sets the pin enable; software clears it for port use.
// [RQ5] Pin not held low at reset release means normal run mode.
// [RQ6] Pin held low at reset release means active background mode.
// [RQ7] Each debug link bit time lasts 16 debug clock cycles.
// [RQ8] Debug link timing runs at the full bus clock rate.
// [RQ9] Pin is pulled low only, with brief driven high speedup pulses.
// [RQ10] Non-intrusive commands are accepted in run and background modes.
// [RQ11] CPU register, trace and go commands work only in background mode.
// [RQ12] Wait stops the CPU clock and clears the interrupt mask bit.
// [RQ13] An interrupt in wait restarts the CPU with the stacking sequence.
// [RQ14] In wait only halt and memory-with-status commands are accepted.
// [RQ15] In wait or stop, memory-with-status returns a status, no access; in stop the code answers it only in standby stop with debug mode enabled.
// [RQ16] Halt received in wait wakes the device into background mode.
// [RQ17] Stop needs the stop enable; both stop modes halt bus and CPU.
// [RQ18] Debug mode enabled turns a partial power-down stop into standby.
// [RQ19] Low-voltage stop enable turns partial power-down into standby; the code also requires the low-voltage detect enable.
// [RQ20] Standby stop keeps regulator full on if debug or LOW_VOLTAGE_DETECTOR enabled.
// [RQ21] Converter runs in standby stop only with async clock and LOW_VOLTAGE_DETECTOR on.
// [RQ22] Clock source runs in standby stop only with both ref enables set.
// [RQ23] Write-once select chooses standby stop (0) or power-down stop (1).
// [RQ24] Recovery from power-down stop sets a flag; writing ack 1 clears it.
// [RQ25] Both stop modes hold pin states; RAM is retained.
`timescale 1ns/1ps
`include "omc_defines.vh"
`default_nettype none

module omc_operating_mode_controller #(
    parameter BIT_CYCLES = `OMC_BIT_CYCLES,
    parameter SAMPLE_CYCLES = `OMC_SAMPLE_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire [`OMC_ADDR_W-1:0] reg_addr,
    input wire [`OMC_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`OMC_DATA_W-1:0] reg_rdata,
    input wire debug_mode_pin_in,
    output reg debug_mode_pin_out,
    output reg debug_mode_pin_oe_n,
    output reg debug_pin_pullup_en,
    output reg debug_pin_is_link,
    input wire tx_bit_valid,
    input wire tx_bit_value,
    output reg tx_bit_done,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    output reg cmd_accept,
    output reg cmd_reject,
    output reg cmd_status_stopwait,
    output reg cpu_step,
    input wire wait_exec,
    input wire stop_exec,
    input wire irq_req,
    input wire stop_wake,
    output reg cpu_clk_en,
    output reg bus_clk_en,
    output reg ccr_imask_clear,
    output reg irq_stack_start,
    output reg in_background,
    output reg regulator_full_on,
    output reg adc_run,
    output reg ics_run,
    output reg io_hold,
    output reg ram_retain,
    output reg debug_force_reset
);

    localparam [2:0] MODE_SAMPLE = `OMC_MODE_SAMPLE;
    localparam [2:0] MODE_RUN = `OMC_MODE_RUN;
    localparam [2:0] MODE_BACKGROUND = `OMC_MODE_BACKGROUND;
    localparam [2:0] MODE_WAIT = `OMC_MODE_WAIT;
    localparam [2:0] MODE_STANDBY_STOP = `OMC_MODE_STANDBY_STOP;
    localparam [2:0] MODE_PPD_STOP = `OMC_MODE_PPD_STOP;

    localparam [1:0] TX_IDLE = 2'h0;
    localparam [1:0] TX_LOW = 2'h1;
    localparam [1:0] TX_SPEEDUP = 2'h2;
    localparam [1:0] TX_REST = 2'h3;

    localparam [4:0] BIT_LAST = BIT_CYCLES[4:0] - 5'h01;
    localparam [4:0] ZERO_LOW = `OMC_ZERO_LOW_CYCLES;
    localparam [4:0] ONE_LOW = `OMC_ONE_LOW_CYCLES;
    localparam [4:0] SPEEDUP = `OMC_SPEEDUP_CYCLES;
    localparam [2:0] SAMPLE_LAST = SAMPLE_CYCLES[2:0] - 3'h1;

    reg debug_pin_enable_reg;
    reg stop_instruction_enable_reg;
    reg debug_mode_enable_reg;
    reg ppd_select_reg;
    reg ppd_select_written_reg;
    reg lowvolt_detect_enable_reg;
    reg lowvolt_stop_enable_reg;
    reg ppd_flag_reg;
    reg internal_ref_clock_enable_reg;
    reg internal_ref_stop_enable_reg;
    reg adc_async_clock_enable_reg;

    reg [2:0] mode_reg;
    reg [2:0] mode_next;
    reg [2:0] sample_cnt_reg;
    reg [2:0] pin_sync_reg;

    reg [1:0] tx_state_reg;
    reg [1:0] tx_state_next;
    reg [4:0] tx_cnt_reg;
    reg [4:0] tx_cnt_next;
    reg [4:0] tx_low_reg;
    reg [4:0] tx_low_next;

    wire wr_sysopt = reg_wr && (reg_addr == `OMC_OFS_SYSTEM_OPTIONS_1);
    wire wr_dbgctl = reg_wr && (reg_addr == `OMC_OFS_DEBUG_CONTROL);
    wire wr_power = reg_wr && (reg_addr == `OMC_OFS_POWER_CONTROL);
    wire wr_clock = reg_wr && (reg_addr == `OMC_OFS_CLOCK_SOURCE_CONTROL_1);
    wire wr_force = reg_wr && (reg_addr == `OMC_OFS_DEBUG_FORCE_RESET_REG);

    // The pin level counts only once the second and third stages agree.
    wire pin_stable = (pin_sync_reg[1] == pin_sync_reg[2]);
    wire pin_low = pin_stable && !pin_sync_reg[2];

    wire in_stop = (mode_reg == MODE_STANDBY_STOP) ||
                   (mode_reg == MODE_PPD_STOP);
    wire stop_ok = stop_exec && stop_instruction_enable_reg; // RQ17
    wire lvd_in_stop = lowvolt_detect_enable_reg && lowvolt_stop_enable_reg;
    wire ppd_allowed = ppd_select_reg && !debug_mode_enable_reg && // RQ18
                       !lvd_in_stop; // RQ19

    reg cmd_ok;
    reg cmd_noaccess;
    always @* begin
        cmd_ok = 1'b0;
        cmd_noaccess = 1'b0;
        case (mode_reg)
            MODE_RUN: cmd_ok = (cmd_code <= `OMC_CMD_HALT); // RQ10 RQ11
            MODE_BACKGROUND: cmd_ok = (cmd_code <= `OMC_CMD_GO); // RQ10 RQ11
            MODE_WAIT: begin
                cmd_ok = (cmd_code == `OMC_CMD_HALT) ||
                         (cmd_code == `OMC_CMD_MEM_STATUS); // RQ14
                cmd_noaccess = (cmd_code == `OMC_CMD_MEM_STATUS); // RQ15
            end
            MODE_STANDBY_STOP: begin
                // The debug controller only lives on here if enabled.
                cmd_ok = debug_mode_enable_reg &&
                         (cmd_code == `OMC_CMD_MEM_STATUS);
                cmd_noaccess = cmd_ok; // RQ15
            end
            default: cmd_ok = 1'b0;
        endcase
    end

    wire cmd_take = cmd_valid && cmd_ok;

    always @* begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_SAMPLE: begin
                // The decision waits for the synchroniser to fill.
                if (sample_cnt_reg == SAMPLE_LAST && pin_stable) begin
                    if (pin_low) begin
                        mode_next = MODE_BACKGROUND; // RQ6
                    end else begin
                        mode_next = MODE_RUN; // RQ5
                    end
                end
            end
            MODE_RUN: begin
                if (cmd_take && cmd_code == `OMC_CMD_HALT) begin
                    mode_next = MODE_BACKGROUND;
                end else if (wait_exec) begin
                    mode_next = MODE_WAIT; // RQ12
                end else if (stop_ok) begin
                    if (ppd_allowed) begin
                        mode_next = MODE_PPD_STOP; // RQ23
                    end else begin
                        mode_next = MODE_STANDBY_STOP; // RQ23
                    end
                end
            end
            MODE_BACKGROUND: begin
                if (cmd_take && cmd_code == `OMC_CMD_GO) begin
                    mode_next = MODE_RUN; // RQ11
                end
            end
            MODE_WAIT: begin
                if (cmd_take && cmd_code == `OMC_CMD_HALT) begin
                    mode_next = MODE_BACKGROUND; // RQ16
                end else if (irq_req) begin
                    mode_next = MODE_RUN; // RQ13
                end
            end
            MODE_STANDBY_STOP: begin
                if (stop_wake || irq_req) begin
                    mode_next = MODE_RUN;
                end
            end
            MODE_PPD_STOP: begin
                if (stop_wake) begin
                    mode_next = MODE_RUN;
                end
            end
            default: mode_next = MODE_SAMPLE;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_sync_reg <= 3'h7;
            sample_cnt_reg <= 3'h0;
            mode_reg <= MODE_SAMPLE; // RQ1
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], debug_mode_pin_in};
            if (mode_reg == MODE_SAMPLE && sample_cnt_reg != SAMPLE_LAST) begin
                sample_cnt_reg <= sample_cnt_reg + 3'h1;
            end
            mode_reg <= mode_next;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            debug_pin_enable_reg <= `OMC_RST_DEBUG_PIN_ENABLE; // RQ4
            stop_instruction_enable_reg <= `OMC_RST_STOP_INSTRUCTION_ENABLE;
            debug_mode_enable_reg <= `OMC_RST_DEBUG_MODE_ENABLE;
            ppd_select_reg <= 1'b0;
            ppd_select_written_reg <= 1'b0;
            lowvolt_detect_enable_reg <= 1'b0;
            lowvolt_stop_enable_reg <= 1'b0;
            ppd_flag_reg <= 1'b0;
            internal_ref_clock_enable_reg <= 1'b0;
            internal_ref_stop_enable_reg <= 1'b0;
            adc_async_clock_enable_reg <= 1'b0;
            debug_force_reset <= 1'b0;
        end else begin
            if (wr_sysopt) begin
                debug_pin_enable_reg <=
                    reg_wdata[`OMC_BIT_DEBUG_PIN_ENABLE]; // RQ4
                stop_instruction_enable_reg <=
                    reg_wdata[`OMC_BIT_STOP_INSTRUCTION_ENABLE];
            end
            if (wr_dbgctl) begin
                debug_mode_enable_reg <= reg_wdata[`OMC_BIT_DEBUG_MODE_ENABLE];
            end
            if (wr_power) begin
                lowvolt_detect_enable_reg <=
                    reg_wdata[`OMC_BIT_LOWVOLT_DETECT_ENABLE];
                lowvolt_stop_enable_reg <=
                    reg_wdata[`OMC_BIT_LOWVOLT_STOP_ENABLE];
                // Later writes to the select are ignored until reset.
                if (!ppd_select_written_reg) begin
                    ppd_select_reg <= reg_wdata[`OMC_BIT_PPD_SELECT]; // RQ23
                    ppd_select_written_reg <= 1'b1;
                end
            end
            if (wr_clock) begin
                internal_ref_clock_enable_reg <=
                    reg_wdata[`OMC_BIT_INTERNAL_REF_CLOCK_ENABLE];
                internal_ref_stop_enable_reg <=
                    reg_wdata[`OMC_BIT_INTERNAL_REF_STOP_ENABLE];
                adc_async_clock_enable_reg <=
                    reg_wdata[`OMC_BIT_ADC_ASYNC_CLOCK_ENABLE];
            end
            // Recovery sets the flag; a same-cycle ack does not lose it.
            if (mode_reg == MODE_PPD_STOP && mode_next == MODE_RUN) begin
                ppd_flag_reg <= 1'b1; // RQ24
            end else if (wr_power && reg_wdata[`OMC_BIT_PPD_ACK]) begin
                ppd_flag_reg <= 1'b0; // RQ24
            end
            debug_force_reset <= wr_force && reg_wdata[`OMC_BIT_FORCE_RESET];
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `OMC_OFS_SYSTEM_OPTIONS_1: begin
                    reg_rdata <= {6'h00, stop_instruction_enable_reg,
                                  debug_pin_enable_reg};
                end
                `OMC_OFS_DEBUG_CONTROL: begin
                    reg_rdata <= {7'h00, debug_mode_enable_reg};
                end
                `OMC_OFS_POWER_CONTROL: begin
                    reg_rdata <= {4'h0, ppd_flag_reg, lowvolt_stop_enable_reg,
                                  lowvolt_detect_enable_reg, ppd_select_reg};
                end
                `OMC_OFS_CLOCK_SOURCE_CONTROL_1: begin
                    reg_rdata <= {5'h00, adc_async_clock_enable_reg,
                                  internal_ref_stop_enable_reg,
                                  internal_ref_clock_enable_reg};
                end
                `OMC_OFS_MODE_STATUS: reg_rdata <= {5'h00, mode_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
            cmd_status_stopwait <= 1'b0;
            cpu_step <= 1'b0;
            cpu_clk_en <= 1'b0;
            bus_clk_en <= 1'b1;
            ccr_imask_clear <= 1'b0;
            irq_stack_start <= 1'b0;
            in_background <= 1'b0;
            regulator_full_on <= 1'b1;
            adc_run <= 1'b1;
            ics_run <= 1'b1;
            io_hold <= 1'b0;
            ram_retain <= 1'b1;
            debug_pin_pullup_en <= 1'b1;
            debug_pin_is_link <= 1'b0;
        end else begin
            cmd_accept <= cmd_take;
            cmd_reject <= cmd_valid && !cmd_ok;
            cmd_status_stopwait <= cmd_take && cmd_noaccess; // RQ15
            cpu_step <= cmd_take && cmd_code == `OMC_CMD_TRACE &&
                        mode_reg == MODE_BACKGROUND; // RQ11
            cpu_clk_en <= (mode_next == MODE_RUN); // RQ12 RQ17
            bus_clk_en <= !((mode_next == MODE_STANDBY_STOP) ||
                            (mode_next == MODE_PPD_STOP)); // RQ17
            ccr_imask_clear <= (mode_reg == MODE_RUN) &&
                               (mode_next == MODE_WAIT); // RQ12
            irq_stack_start <= (mode_reg == MODE_WAIT) &&
                               (mode_next == MODE_RUN); // RQ13
            in_background <= (mode_next == MODE_BACKGROUND);
            io_hold <= (mode_next == MODE_STANDBY_STOP) ||
                       (mode_next == MODE_PPD_STOP); // RQ25
            ram_retain <= 1'b1; // RQ25
            if (mode_next == MODE_STANDBY_STOP) begin
                regulator_full_on <= debug_mode_enable_reg ||
                                     lvd_in_stop; // RQ20
                adc_run <= adc_async_clock_enable_reg &&
                           lvd_in_stop; // RQ21
                ics_run <= internal_ref_clock_enable_reg &&
                           internal_ref_stop_enable_reg; // RQ22
            end else if (mode_next == MODE_PPD_STOP) begin
                regulator_full_on <= 1'b0;
                adc_run <= 1'b0;
                ics_run <= 1'b0;
            end else begin
                regulator_full_on <= 1'b1;
                adc_run <= 1'b1;
                ics_run <= 1'b1;
            end
            debug_pin_pullup_en <= debug_pin_enable_reg; // RQ3
            debug_pin_is_link <= debug_pin_enable_reg &&
                                 (mode_reg != MODE_SAMPLE); // RQ1 RQ2
        end
    end

    // Holding the pin high would fight the host, so high is never held.
    always @* begin
        tx_state_next = tx_state_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_low_next = tx_low_reg;
        case (tx_state_reg)
            TX_IDLE: begin
                tx_cnt_next = 5'h00;
                if (tx_bit_valid && debug_pin_is_link && !in_stop) begin
                    tx_low_next = tx_bit_value ? ONE_LOW : ZERO_LOW;
                    tx_state_next = TX_LOW;
                end
            end
            TX_LOW: begin
                tx_cnt_next = tx_cnt_reg + 5'h01;
                if (tx_cnt_reg == tx_low_reg - 5'h01) begin
                    tx_state_next = TX_SPEEDUP; // RQ9
                end
            end
            TX_SPEEDUP: begin
                tx_cnt_next = tx_cnt_reg + 5'h01;
                if (tx_cnt_reg == tx_low_reg + SPEEDUP - 5'h01) begin
                    tx_state_next = TX_REST;
                end
            end
            TX_REST: begin
                tx_cnt_next = tx_cnt_reg + 5'h01;
                if (tx_cnt_reg == BIT_LAST) begin
                    tx_state_next = TX_IDLE; // RQ7 RQ8
                end
            end
            default: tx_state_next = TX_IDLE;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg <= 5'h00;
            tx_low_reg <= 5'h00;
            tx_bit_done <= 1'b0;
            debug_mode_pin_out <= 1'b0;
            debug_mode_pin_oe_n <= 1'b1; // RQ1
        end else begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_low_reg <= tx_low_next;
            tx_bit_done <= (tx_state_reg == TX_REST) &&
                           (tx_cnt_reg == BIT_LAST); // RQ7
            debug_mode_pin_out <= (tx_state_next == TX_SPEEDUP); // RQ9
            debug_mode_pin_oe_n <= !((tx_state_next == TX_LOW) ||
                                     (tx_state_next == TX_SPEEDUP)); // RQ9
        end
    end

endmodule // omc_operating_mode_controller

`default_nettype wire

//--- bench/omc_host_model.sv
// Debug host on the shared pin: open-drain wire with pull-up.
// Assumes the block drives the pin low or with short high pulses only.
`timescale 1ns/1ps
`default_nettype none
module omc_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic bg_req,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output wire logic pin_level
);
    logic [3:0] hold;
    // The host keeps the pin low past release so the sampler sees it.
    always @(posedge clk or posedge rst) begin
        if (rst) hold <= 4'ha;
        else if (hold != 4'h0) hold <= hold - 4'h1;
    end
    wire logic host_low = bg_req && (rst || hold != 4'h0);
    assign pin_level = host_low ? 1'b0 : (!pin_oe_n ? pin_out : 1'b1);
endmodule // omc_host_model
`default_nettype wire

//--- bench/omc_chk_chk.sv
// Checker for the operating mode controller, bound to its ports.
// Assumes one clock and an active high reset.
`timescale 1ns/1ps
`include "omc_defines.vh"
`default_nettype none
module omc_chk #(parameter BIT_CYCLES = 16) (
    input wire clk,
    input wire rst,
    input wire [`OMC_ADDR_W-1:0] reg_addr,
    input wire [`OMC_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire cmd_accept,
    input wire cmd_reject,
    input wire cmd_status_stopwait,
    input wire in_background,
    input wire debug_mode_pin_out,
    input wire debug_mode_pin_oe_n,
    input wire debug_pin_pullup_en,
    input wire debug_pin_is_link,
    input wire tx_bit_done,
    input wire ccr_imask_clear,
    input wire irq_stack_start,
    input wire cpu_clk_en,
    input wire bus_clk_en,
    input wire io_hold
);
    localparam int BC = BIT_CYCLES;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst_pin;
        @(posedge clk) disable iff (1'b0)
        rst |-> debug_mode_pin_oe_n && !debug_pin_is_link;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("pin used in reset");
    property p_pullup;
        reg_wr && reg_addr == `OMC_OFS_SYSTEM_OPTIONS_1 && !reg_wdata[0]
        |-> ##[1:2] !debug_pin_pullup_en;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up stays on");
    property p_answer;
        cmd_valid |=> cmd_accept != cmd_reject;
    endproperty
    a_answer: assert property (p_answer) else $error("no command answer");
    property p_bg_only;
        cmd_valid && cmd_code >= 3'h4 && !in_background |=> cmd_reject;
    endproperty
    a_bg_only: assert property (p_bg_only) else $error("cpu cmd taken");
    property p_wait;
        ccr_imask_clear |-> !cpu_clk_en && $past(cpu_clk_en);
    endproperty
    a_wait: assert property (p_wait) else $error("wait entry wrong");
    property p_irq;
        irq_stack_start |-> cpu_clk_en && !$past(cpu_clk_en);
    endproperty
    a_irq: assert property (p_irq) else $error("wake by irq wrong");
    property p_status;
        cmd_status_stopwait |-> cmd_accept && !cpu_clk_en;
    endproperty
    a_status: assert property (p_status) else $error("status misplaced");
    property p_stop;
        !bus_clk_en |-> !cpu_clk_en && io_hold;
    endproperty
    a_stop: assert property (p_stop) else $error("stop clocks wrong");
    property p_speedup;
        debug_mode_pin_out |-> !debug_mode_pin_oe_n
            ##1 (debug_mode_pin_oe_n && !debug_mode_pin_out);
    endproperty
    a_speedup: assert property (p_speedup) else $error("long high drive");
    property p_bit;
        $fell(debug_mode_pin_oe_n) |-> ##[BC:BC] tx_bit_done;
    endproperty
    a_bit: assert property (p_bit) else $error("bit time wrong");
    c_bit: cover property (tx_bit_done);
    c_halt: cover property (cmd_valid && cmd_code == `OMC_CMD_HALT);
    c_stop: cover property (!bus_clk_en);
endmodule // omc_chk
bind omc_operating_mode_controller omc_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.*);
`default_nettype wire

//--- bench/tb.sv
// Testbench for the operating mode controller with a debug host model.
// Assumes a 50 MHz clock and the register map of the shared header.
`timescale 1ns/1ps
`include "omc_defines.vh"
`default_nettype none
module tb;
    logic clk = 0, rst, bg_req = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic tx_bit_valid = 0, tx_bit_value = 0, cmd_valid = 0, irq_req = 0;
    logic [2:0] cmd_code = 3'h0;
    logic wait_exec = 0, stop_exec = 0, stop_wake = 0;
    wire [7:0] reg_rdata;
    wire debug_mode_pin_in, debug_mode_pin_out, debug_mode_pin_oe_n;
    wire debug_pin_pullup_en, debug_pin_is_link, tx_bit_done, cpu_step;
    wire cmd_accept, cmd_reject, cmd_status_stopwait, debug_force_reset;
    wire cpu_clk_en, bus_clk_en, ccr_imask_clear, irq_stack_start;
    wire in_background, regulator_full_on, adc_run, ics_run, io_hold;
    wire ram_retain;
    wire [7:0] flags = {bus_clk_en, cpu_clk_en, regulator_full_on, adc_run,
        ics_run, io_hold, ram_retain, in_background};
    int error_cnt = 0, samples_checked = 0, n, hi;
    omc_operating_mode_controller DUT (.*);
    omc_host_model u_host (.clk(clk), .rst(rst), .bg_req(bg_req),
        .pin_out(debug_mode_pin_out), .pin_oe_n(debug_mode_pin_oe_n),
        .pin_level(debug_mode_pin_in));
    initial forever #10 clk = ~clk;
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task finish_test;
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task do_rst(input logic bg);
        bg_req <= bg;
        rst <= 1;
        repeat (12) @(posedge clk);
        rst <= 0;
        repeat (12) @(posedge clk);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 0;
        #1;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk);
        reg_rd <= 0;
        #1 chk("rdata", e, reg_rdata);
    endtask
    task cmd(input logic [2:0] c, input logic a, input logic s);
        @(posedge clk);
        cmd_valid <= 1;
        cmd_code <= c;
        @(posedge clk);
        cmd_valid <= 0;
        #1 chk("answer", {4'h0, a && c == `OMC_CMD_TRACE, a, !a, s},
            {4'h0, cpu_step, cmd_accept, cmd_reject, cmd_status_stopwait});
    endtask
    task ev(input logic w, input logic s, input logic k, input logic i);
        @(posedge clk);
        {wait_exec, stop_exec, stop_wake, irq_req} <= {w, s, k, i};
        @(posedge clk);
        {wait_exec, stop_exec, stop_wake, irq_req} <= 4'h0;
        #1;
    endtask
    task tbit(input logic v);
        @(posedge clk);
        tx_bit_valid <= 1;
        tx_bit_value <= v;
        @(posedge clk);
        tx_bit_valid <= 0;
        n = 1;
        hi = 0;
        #1;
        while (tx_bit_done !== 1'b1 && n < 40) begin
            hi += (debug_mode_pin_out === 1'b1);
            @(posedge clk);
            #1 n++;
        end
        chk("bit_len", 8'd17, n[7:0]);
        chk("speedup", 8'd1, hi[7:0]);
    endtask
    initial begin
        #400000 error_cnt++;
        finish_test;
    end
    initial begin
        do_rst(0);
        rd(`OMC_OFS_MODE_STATUS, {5'h0, `OMC_MODE_RUN});
        rd(`OMC_OFS_SYSTEM_OPTIONS_1, 8'h01);
        chk("link", 8'h03, {6'h0, debug_pin_pullup_en, debug_pin_is_link});
        rd(4'hf, 8'h00);
        for (int c = 0; c < 8; c++) begin
            if (c != 3) cmd(c[2:0], c < 3, 0);
        end
        cmd(`OMC_CMD_HALT, 1, 0);
        for (int c = 0; c < 7; c++) cmd(c[2:0], 1, 0);
        rd(`OMC_OFS_MODE_STATUS, {5'h0, `OMC_MODE_RUN});
        tbit(0);
        tbit(1);
        ev(1, 0, 0, 0);
        chk("imask", 8'h01, {6'h0, cpu_clk_en, ccr_imask_clear});
        cmd(`OMC_CMD_MEM, 0, 0);
        cmd(`OMC_CMD_MEM_STATUS, 1, 1);
        ev(0, 0, 0, 1);
        chk("stack", 8'h03, {6'h0, cpu_clk_en, irq_stack_start});
        ev(1, 0, 0, 0);
        cmd(`OMC_CMD_HALT, 1, 0);
        chk("bg", 8'h01, {7'h0, in_background});
        cmd(`OMC_CMD_GO, 1, 0);
        ev(0, 1, 0, 0);
        rd(`OMC_OFS_MODE_STATUS, {5'h0, `OMC_MODE_RUN});
        wr(`OMC_OFS_SYSTEM_OPTIONS_1, 8'h03);
        wr(`OMC_OFS_POWER_CONTROL, 8'h01);
        wr(`OMC_OFS_DEBUG_CONTROL, 8'h01);
        wr(`OMC_OFS_CLOCK_SOURCE_CONTROL_1, 8'h07);
        ev(0, 1, 0, 0);
        chk("stby", 8'h2e, flags);
        cmd(`OMC_CMD_MEM_STATUS, 1, 1);
        ev(0, 0, 1, 0);
        wr(`OMC_OFS_DEBUG_CONTROL, 8'h00);
        wr(`OMC_OFS_POWER_CONTROL, 8'h06);
        ev(0, 1, 0, 0);
        chk("lvd", 8'h3e, flags);
        ev(0, 0, 1, 0);
        wr(`OMC_OFS_POWER_CONTROL, 8'h00);
        ev(0, 1, 0, 0);
        chk("ppd", 8'h06, flags);
        ev(0, 0, 1, 0);
        rd(`OMC_OFS_POWER_CONTROL, 8'h09);
        wr(`OMC_OFS_POWER_CONTROL, 8'h11);
        rd(`OMC_OFS_POWER_CONTROL, 8'h01);
        wr(`OMC_OFS_SYSTEM_OPTIONS_1, 8'h02);
        @(posedge clk);
        #1 chk("pullup", 8'h00, {7'h0, debug_pin_pullup_en});
        wr(`OMC_OFS_DEBUG_FORCE_RESET_REG, 8'h01);
        chk("force", 8'h01, {7'h0, debug_force_reset});
        do_rst(1);
        rd(`OMC_OFS_MODE_STATUS, {5'h0, `OMC_MODE_BACKGROUND});
        rd(`OMC_OFS_SYSTEM_OPTIONS_1, 8'h01);
        finish_test;
    end
endmodule // tb
`default_nettype wire
